//--- inc/sarx_pkg.sv
// Constants, carriers and state codes for the satellite audio frame receiver
package sarx_pkg;
	// Sync word, one 2-bit phase index per symbol, first symbol in the top bits
	localparam int SYNC_LEN = 16;
	localparam logic [31:0] SYNC_WORD = 32'hE4B1_2D78;
	localparam int CORR_W = 5;
	// Lattice equalizer shape
	localparam int FF_TAPS = 22;
	localparam int FB_TAPS = 4;
	localparam int EQ_W = 12;
	localparam int ACQ_SYMBOLS = 100;
	localparam logic [6:0] ACQ_LAST = 7'h63;
	localparam logic signed [11:0] RAIL_AMP = 12'sh040;
	localparam logic signed [11:0] UNITY_GAIN = 12'sh040;
	localparam logic signed [11:0] STEP_COARSE = 12'sh004;
	localparam logic signed [11:0] STEP_FINE = 12'sh001;
	// Interleaver block, rows by columns, ping-pong banked
	localparam int ROWS = 8;
	localparam int COLS = 16;
	localparam int BLOCK = 128;
	localparam logic [6:0] BLOCK_LAST = 7'h7F;
	localparam logic [3:0] SYNC_LAST = 4'hF;
	localparam logic [3:0] SYNC_EARLY = 4'hE;
	// Frame tracking
	localparam logic [1:0] MISS_MAX = 2'h3;
	localparam logic [3:0] ECHO_WIN = 4'h4;
	localparam logic [1:0] TRAIN_SYM = 2'h0;
	// Transmission identifier fields
	localparam int TID_W = 8;
	localparam int TID_TRAIN_LSB = 0;
	localparam int TID_CFG_LSB = 2;
	localparam int CFG_W = 6;

	typedef struct packed {
		logic valid;
		logic second;
		logic signed [7:0] i;
		logic signed [7:0] q;
	} sarx_sample_t;

	typedef struct packed {
		logic valid;
		logic sop;
		logic [1:0] data;
	} sarx_sym_t;

	typedef enum logic [1:0] {
		ST_HUNT = 2'b01,
		ST_LOCK = 2'b10
	} sarx_state_t;
endpackage

//--- design/sarx_frame_rx.sv
// Frame sync, equalizer control, training removal and de-interleaving
`timescale 1ns/1ns
module sarx_frame_rx (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire sarx_pkg::sarx_sample_t samp,
	input wire logic [sarx_pkg::TID_W-1:0] tid,
	input wire logic eq_manual,
	input wire logic eq_bypass,
	input wire logic [sarx_pkg::CORR_W-1:0] lock_thresh,
	input wire logic [15:0] fft_freq_est,
	output logic [sarx_pkg::CFG_W-1:0] demux_cfg,
	output logic frame_lock,
	output logic eq_active,
	output logic eq_acquired,
	output logic loops_open,
	output logic sample_2x,
	output logic [15:0] carrier_ref,
	output logic timing_early,
	output logic timing_late,
	output sarx_pkg::sarx_sym_t sym_out
);
	import sarx_pkg::*;

	function automatic logic [1:0] quad(input logic neg_i, input logic neg_q);
		return {neg_q, neg_i ^ neg_q};
	endfunction

	function automatic logic signed [11:0] rail(input logic [1:0] ph, input logic q_rail);
		logic neg;
		neg = q_rail ? ph[1] : (ph[1] ^ ph[0]);
		return neg ? -RAIL_AMP : RAIL_AMP;
	endfunction

	function automatic logic signed [11:0] mul_sh(input logic signed [11:0] a, input logic signed [11:0] b);
		logic signed [23:0] p;
		p = a * b;
		return p[17:6];
	endfunction

	// Config pins are asynchronous to the core, two stages each
	logic [TID_W+CORR_W+1:0] cfg_m, cfg_s;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_m <= '0;
			cfg_s <= '0;
		end else if (clk_en) begin
			cfg_m <= {tid, lock_thresh, eq_manual, eq_bypass};
			cfg_s <= cfg_m;
		end
	end
	wire [TID_W-1:0] tid_s = cfg_s[TID_W+CORR_W+1:CORR_W+2];
	wire [CORR_W-1:0] thresh_s = cfg_s[CORR_W+1:2];
	wire manual_s = cfg_s[1];
	wire bypass_s = cfg_s[0];

	wire [1:0] train_code = tid_s[TID_TRAIN_LSB+1:TID_TRAIN_LSB];
	wire train_on = train_code != 2'h0;
	wire [2:0] train_n = {1'b0, train_code} + 3'h1;

	wire sym_ev = clk_en & samp.valid & samp.second;
	wire samp_ev = clk_en & samp.valid;

	// Equalizer, one real lattice per rail
	logic [1:0] rot;
	logic is_train;
	logic [6:0] acq_cnt;
	wire [1:0] train_ref = TRAIN_SYM + rot;
	logic signed [11:0] y [2];
	logic signed [11:0] e [2];
	wire [1:0] eq_dec = quad(y[0][11], y[1][11]);
	wire [1:0] ref_ph = (is_train && frame_lock) ? train_ref : eq_dec;
	wire signed [11:0] step = eq_acquired ? STEP_FINE : STEP_COARSE;

	for (genvar r = 0; r < 2; r++) begin : g_rail
		logic signed [11:0] bd [FF_TAPS];
		logic signed [11:0] kc [FF_TAPS];
		logic signed [11:0] g [FF_TAPS];
		logic signed [11:0] fw [FB_TAPS];
		logic signed [11:0] dh [FB_TAPS];
		logic signed [11:0] f [FF_TAPS];
		logic signed [11:0] b [FF_TAPS];
		logic signed [11:0] acc;
		wire signed [7:0] xr = r ? samp.q : samp.i;
		wire signed [11:0] refv = rail(ref_ph, r == 1);
		// lattice predictor stages, forward taps, then feedback
		always_comb begin
			acc = '0;
			f[0] = {{4{xr[7]}}, xr};
			b[0] = {{4{xr[7]}}, xr};
			for (int m = 1; m < FF_TAPS; m++) begin
				f[m] = f[m-1] - mul_sh(kc[m], bd[m-1]);
				b[m] = bd[m-1] - mul_sh(kc[m], f[m-1]);
			end
			for (int m = 0; m < FF_TAPS; m++)
				acc = acc + mul_sh(g[m], b[m]);
			for (int j = 0; j < FB_TAPS; j++)
				acc = acc - mul_sh(fw[j], dh[j]);
			y[r] = acc;
			e[r] = refv - acc;
		end
		// Sign-sign adaptation; coefficients restart whenever eq_active is low
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				for (int m = 0; m < FF_TAPS; m++) begin
					bd[m] <= '0;
					kc[m] <= '0;
					g[m] <= (m == 0) ? UNITY_GAIN : 12'sh000;
				end
				for (int j = 0; j < FB_TAPS; j++) begin
					fw[j] <= '0;
					dh[j] <= '0;
				end
			end else if (clk_en && !eq_active) begin
				for (int m = 0; m < FF_TAPS; m++) begin
					kc[m] <= '0;
					g[m] <= (m == 0) ? UNITY_GAIN : 12'sh000;
				end
				for (int j = 0; j < FB_TAPS; j++)
					fw[j] <= '0;
			end else if (samp_ev) begin
				// every half-symbol sample shifts the lattice
				for (int m = 0; m < FF_TAPS; m++)
					bd[m] <= b[m];
				if (samp.second) begin
					for (int m = 0; m < FF_TAPS; m++) begin
						g[m] <= (e[r][11] ^ b[m][11]) ? g[m] - step : g[m] + step;
						if (m > 0)
							kc[m] <= (f[m-1][11] ^ bd[m-1][11]) ? kc[m] - step : kc[m] + step;
					end
					for (int j = 0; j < FB_TAPS; j++)
						fw[j] <= (e[r][11] ^ dh[j][11]) ? fw[j] + step : fw[j] - step;
					dh[0] <= refv;
					for (int j = 1; j < FB_TAPS; j++)
						dh[j] <= dh[j-1];
				end
			end
		end
	end

	wire [1:0] sym_ph = eq_active ? eq_dec : quad(samp.i[7], samp.q[7]);

	// correlate against all four phase rotations
	logic [31:0] win;
	wire [31:0] next_win = {win[29:0], sym_ph};
	logic [CORR_W-1:0] score [4];
	for (genvar k = 0; k < 4; k++) begin : g_rot
		always_comb begin
			score[k] = '0;
			for (int n = 0; n < SYNC_LEN; n++)
				score[k] = score[k] + CORR_W'(next_win[2*n +: 2] == 2'(SYNC_WORD[2*n +: 2] + 2'(k)));
		end
	end
	wire [1:0] best_ab = (score[1] > score[0]) ? 2'h1 : 2'h0;
	wire [1:0] best_cd = (score[3] > score[2]) ? 2'h3 : 2'h2;
	wire [1:0] best_r = (score[best_cd] > score[best_ab]) ? best_cd : best_ab;
	// only a peak above the threshold counts
	wire peak = sym_ev && (score[best_r] > thresh_s);

	// Frame tracking
	sarx_state_t state;
	logic in_sync;
	logic [6:0] data_cnt;
	logic [3:0] sync_cnt;
	logic [2:0] tph;
	logic [1:0] misses;
	logic [3:0] gap;
	logic echo_seen;
	logic wbank, rd_ok;
	logic [1:0] mem [2*BLOCK];
	// training sits every n+1th payload slot after the sync word
	assign is_train = state == ST_LOCK && !in_sync && train_on && tph == train_n;
	wire data_ev = sym_ev && state == ST_LOCK && !in_sync && !is_train;
	wire hit = in_sync && sync_cnt == SYNC_LAST;
	wire miss_out = hit && !peak && misses == MISS_MAX - 2'h1;
	// manual wins, then bypass, then echo detection
	wire next_eq = manual_s | (!bypass_s & echo_seen);
	// received order is column-major, read back row-major
	wire [7:0] waddr = {wbank, data_cnt};
	wire [7:0] raddr = {~wbank, data_cnt[3:0], data_cnt[6:4]};

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_HUNT;
			win <= '0;
			in_sync <= 1'b0;
			data_cnt <= '0;
			sync_cnt <= '0;
			tph <= '0;
			misses <= '0;
			gap <= '0;
			echo_seen <= 1'b0;
			rot <= '0;
			wbank <= 1'b0;
			rd_ok <= 1'b0;
		end else if (sym_ev) begin
			win <= next_win;
			// closely spaced correlation peaks mark echoes
			gap <= peak ? 4'h1 : ((gap != 4'h0 && gap < ECHO_WIN) ? gap + 4'h1 : 4'h0);
			if (peak && gap != 4'h0)
				echo_seen <= 1'b1;
			case (state)
				ST_HUNT: begin
					if (peak) begin
						state <= ST_LOCK;
						rot <= best_r;
						in_sync <= 1'b0;
						data_cnt <= '0;
						tph <= '0;
						misses <= '0;
						rd_ok <= 1'b0;
					end
				end
				ST_LOCK: begin
					if (!in_sync) begin
						tph <= (train_on && tph == train_n) ? 3'h0 : tph + 3'h1;
						if (data_ev) begin
							data_cnt <= data_cnt + 7'h1;
							if (data_cnt == BLOCK_LAST) begin
								in_sync <= 1'b1;
								sync_cnt <= '0;
								wbank <= ~wbank;
								rd_ok <= 1'b1;
							end
						end
					end else begin
						sync_cnt <= sync_cnt + 4'h1;
						if (hit) begin
							in_sync <= 1'b0;
							tph <= '0;
							data_cnt <= '0;
							if (peak) begin
								rot <= best_r;
								misses <= '0;
							end else begin
								misses <= misses + 2'h1;
							end
						end
					end
					if (miss_out) begin
						state <= ST_HUNT;
						echo_seen <= 1'b0;
					end
				end
				default: state <= ST_HUNT;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (data_ev)
			mem[waddr] <= sym_ph - rot;
	end

	// Status and data outputs, all registered
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			demux_cfg <= '0;
			frame_lock <= 1'b0;
			eq_active <= 1'b0;
			loops_open <= 1'b0;
			sample_2x <= 1'b0;
			carrier_ref <= '0;
			eq_acquired <= 1'b0;
			acq_cnt <= '0;
			timing_early <= 1'b0;
			timing_late <= 1'b0;
			sym_out <= '0;
		end else if (clk_en) begin
			demux_cfg <= tid_s[TID_CFG_LSB +: CFG_W];
			frame_lock <= (state == ST_LOCK) && !(sym_ev && miss_out);
			eq_active <= next_eq;
			loops_open <= next_eq;
			sample_2x <= next_eq;
			// FFT estimate frozen as fixed reference
			if (!loops_open && next_eq)
				carrier_ref <= fft_freq_est;
			// coarse steps for at most 100 symbols
			if (!eq_active) begin
				acq_cnt <= '0;
				eq_acquired <= 1'b0;
			end else if (sym_ev && !eq_acquired) begin
				acq_cnt <= acq_cnt + 7'h1;
				eq_acquired <= acq_cnt == ACQ_LAST;
			end
			// local sync timing against correlator peak
			timing_early <= eq_active && peak && in_sync && sync_cnt == SYNC_EARLY;
			timing_late <= eq_active && peak && state == ST_LOCK && !in_sync && data_cnt == 7'h0 && tph == 3'h0
				&& misses != 2'h0;
			// only data symbols reach the output
			sym_out.valid <= data_ev && rd_ok;
			sym_out.sop <= data_ev && rd_ok && data_cnt == 7'h0;
			sym_out.data <= mem[raddr];
		end
	end

	a_acq_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
		acq_cnt <= ACQ_LAST + 7'h1) else $error("equalizer acquisition overran");
	a_acq_done: assert property (@(posedge core_clk) disable iff (!rst_n)
		eq_active && acq_cnt == ACQ_LAST && sym_ev && !eq_acquired |=> eq_acquired)
		else $error("equalizer not acquired at limit");
	a_loops_open: assert property (@(posedge core_clk) disable iff (!rst_n)
		loops_open == eq_active) else $error("loops not open with equalizer");
	a_ref_fixed: assert property (@(posedge core_clk) disable iff (!rst_n)
		loops_open && $past(loops_open) |-> $stable(carrier_ref)) else $error("carrier reference moved");
	a_two_samples: assert property (@(posedge core_clk) disable iff (!rst_n)
		sample_2x == eq_active) else $error("sample rate not tied to equalizer");
	a_manual_on: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && manual_s |=> eq_active) else $error("manual enable ignored");
	a_bypass_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && bypass_s && !manual_s |=> !eq_active) else $error("bypass ignored");
	a_lock_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
		state == ST_HUNT && sym_ev && peak |=> state == ST_LOCK ##1 (frame_lock || !$past(clk_en)))
		else $error("lock not declared after peak");
	a_train_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
		is_train && sym_ev |=> !sym_out.valid) else $error("training symbol passed");
	a_lock_needs_peak: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(state == ST_LOCK) |-> $past(score[best_r]) > $past(thresh_s)) else $error("lock without peak");
endmodule

//--- test/sarx_tx_model.sv
// Transmitter model: sync word, training slots and block interleaved payload
`timescale 1ns/1ns
module sarx_tx_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic en,
	input wire logic [1:0] train,
	input wire logic [1:0] rot,
	input wire logic sync_on,
	input wire logic mode2x,
	output sarx_pkg::sarx_sample_t samp
);
	import sarx_pkg::*;
	logic [4:0] pos;
	logic [7:0] dc;
	logic [2:0] tph;
	logic half;
	logic slot_train;
	logic [6:0] k;
	logic [1:0] raw;
	logic [1:0] sym;
	logic signed [7:0] iv;
	logic signed [7:0] qv;
	logic take;
	// training after every n data symbols, n = code + 1
	assign slot_train = train != 2'h0 && dc != 8'h00 && tph == {1'b0, train} + 3'h1;
	assign k = {dc[2:0], dc[6:3]};
	// sync word opens the frame; coding is not modelled
	assign raw = pos < 5'h10 ? (sync_on ? SYNC_WORD[31 - 2 * pos -: 2] : pos[1:0]) :
		slot_train ? TRAIN_SYM : k[1:0] ^ k[4:3] ^ {k[6], k[2]};
	assign sym = raw + rot;
	assign iv = sym[0] ^ sym[1] ? 8'shC0 : 8'sh40;
	assign qv = sym[1] ? 8'shC0 : 8'sh40;
	// Idle stream shows inverted levels so a stale symbol is never reused
	assign samp = '{valid: run, second: !mode2x || half, i: run ? iv : ~iv, q: run ? qv : ~qv};
	assign take = run && en;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pos <= 5'h00;
			dc <= 8'h00;
			tph <= 3'h0;
			half <= 1'b0;
		end else if (take && mode2x && !half) begin
			half <= 1'b1;
		end else if (take) begin
			half <= 1'b0;
			if (pos < 5'h10) begin
				pos <= pos + 5'h01;
			end else if (slot_train) begin
				tph <= 3'h0;
			end else if (dc == 8'h7F) begin
				pos <= 5'h00;
				dc <= 8'h00;
				tph <= 3'h0;
			end else begin
				dc <= dc + 8'h01;
				tph <= tph + 3'h1;
			end
		end
	end
endmodule

//--- test/tb.sv
// Self-checking bench for the frame receiver
`timescale 1ns/1ns
module tb;
	import sarx_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic en_d = 1'b1;
	logic [TID_W-1:0] tid = 8'h00;
	logic eq_manual = 1'b0;
	logic eq_bypass = 1'b1;
	logic [CORR_W-1:0] lock_thresh = 5'h0C;
	logic [15:0] fft_freq_est = 16'h0000;
	logic run = 1'b0;
	logic gate = 1'b0;
	logic [1:0] rot = 2'h0;
	logic sync_on = 1'b1;
	logic late_seen = 1'b0;
	logic early_seen = 1'b0;
	sarx_sample_t samp;
	sarx_sym_t sym_out;
	logic [CFG_W-1:0] demux_cfg;
	logic [15:0] carrier_ref;
	logic frame_lock, eq_active, eq_acquired, loops_open, sample_2x, timing_early, timing_late;
	logic [2:0] got[$];
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int sev = 0;
	sarx_frame_rx u_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .samp(samp), .tid(tid),
		.eq_manual(eq_manual), .eq_bypass(eq_bypass), .lock_thresh(lock_thresh), .fft_freq_est(fft_freq_est),
		.demux_cfg(demux_cfg), .frame_lock(frame_lock), .eq_active(eq_active), .eq_acquired(eq_acquired),
		.loops_open(loops_open), .sample_2x(sample_2x), .carrier_ref(carrier_ref),
		.timing_early(timing_early), .timing_late(timing_late), .sym_out(sym_out));
	sarx_tx_model u_tx (.core_clk(core_clk), .rst_n(rst_n), .run(run), .en(clk_en), .train(tid[1:0]),
		.rot(rot), .sync_on(sync_on), .mode2x(sample_2x), .samp(samp));
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	task automatic close_out();
		$display("Counts: %0d comparisons, %0d errors", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v);
		comparisons++;
		if (got_v !== exp_v) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got_v, exp_v);
		end
	endtask
	// Frozen cycles hold sym_out, so only fresh pulses are collected
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		en_d <= clk_en;
		clk_en <= !gate || cycles[1:0] != 2'h0;
		if (sym_out.valid === 1'b1 && en_d) got.push_back({sym_out.sop, sym_out.data});
		if (timing_late === 1'b1) late_seen <= 1'b1;
		if (timing_early === 1'b1) early_seen <= 1'b1;
		if (clk_en && samp.valid && samp.second && eq_active === 1'b1) sev <= sev + 1;
		if (cycles == 20000) begin
			errors++;
			close_out();
		end
	end
	task automatic restart();
		@(posedge core_clk);
		run <= 1'b0;
		rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		got.delete();
		run <= 1'b1;
	endtask
	task automatic t_frames(input logic [1:0] code, input logic [1:0] r, input logic g);
		int n;
		logic [6:0] k;
		tid <= {4'h9, code, code};
		rot <= r;
		gate <= g;
		eq_bypass <= !g;
		restart();
		for (n = 0; got.size() < BLOCK && n < 3000; n++) @(posedge core_clk);
		chk(16'(got.size()), 16'(BLOCK));
		for (int j = 0; j < BLOCK && j < got.size(); j++) begin
			k = j[6:0];
			chk({13'h0, got[j]}, {13'h0, k == 7'h00, k[1:0] ^ k[4:3] ^ {k[6], k[2]}});
		end
		chk({10'h0, demux_cfg}, {10'h0, 4'h9, code});
		chk({15'h0, frame_lock}, 16'h0001);
		chk({15'h0, eq_active}, 16'h0000);
		gate <= 1'b0;
		$display("test frames code %0d done", code);
	endtask
	task automatic t_thresh();
		tid <= 8'h24;
		lock_thresh <= 5'h10;
		restart();
		repeat (700) @(posedge core_clk);
		chk({15'h0, frame_lock}, 16'h0000);
		chk(16'(got.size()), 16'h0000);
		lock_thresh <= 5'h0F;
		restart();
		repeat (300) @(posedge core_clk);
		chk({15'h0, frame_lock}, 16'h0001);
		lock_thresh <= 5'h0C;
		$display("test threshold done");
	endtask
	task automatic t_loss();
		int n;
		restart();
		repeat (300) @(posedge core_clk);
		late_seen <= 1'b0;
		sync_on <= 1'b0;
		repeat (280) @(posedge core_clk);
		chk({15'h0, frame_lock}, 16'h0001);
		for (n = 0; frame_lock !== 1'b0 && n < 300; n++) @(posedge core_clk);
		chk({15'h0, frame_lock}, 16'h0000);
		// Equalizer stays off so far, so no timing report is due
		chk({14'h0, early_seen, late_seen}, 16'h0000);
		sync_on <= 1'b1;
		$display("test lock loss done");
	endtask
	task automatic t_eq();
		int s0;
		restart();
		fft_freq_est <= 16'hA5C3;
		eq_manual <= 1'b1;
		repeat (5) @(posedge core_clk);
		s0 = sev;
		fft_freq_est <= 16'h1234;
		chk({12'h0, eq_active, loops_open, sample_2x, 1'b0}, 16'h000E);
		chk(carrier_ref, 16'hA5C3);
		for (int n = 0; sev - s0 < 94 && n < 400; n++) @(posedge core_clk);
		chk({15'h0, eq_acquired}, 16'h0000);
		for (int n = 0; sev - s0 < 104 && n < 400; n++) @(posedge core_clk);
		chk({15'h0, eq_acquired}, 16'h0001);
		chk(carrier_ref, 16'hA5C3);
		eq_manual <= 1'b0;
		repeat (5) @(posedge core_clk);
		chk({12'h0, eq_active, loops_open, sample_2x, 1'b0}, 16'h0000);
		$display("test equalizer done");
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		t_frames(2'h0, 2'h0, 1'b0);
		t_frames(2'h1, 2'h3, 1'b0);
		t_frames(2'h2, 2'h1, 1'b1);
		t_frames(2'h3, 2'h2, 1'b0);
		t_thresh();
		t_loss();
		t_eq();
		close_out();
	end
endmodule
